/* core/fdc_ctrl.sv */
// disk controller: host registers and drive sequencing
// What this block does
// - reset holds device reset and command register at 03
// - not-ready status bit cleared while reset active
// - after reset run restore ignoring ready; sector register becomes 01
// - select 0 status/command, 1 track, 2 sector, 3 data
// - write strobe with chip select loads addressed register from bus
// - read strobe with chip select drives addressed register, inverted
// - data request on byte ready or empty; cleared by data register read or write
// - interrupt at command end; cleared by status read or command write
// - one step pulse per step; direction high inward, low outward
// - early and late hints mark write pulses to shift
// - head engaged input high means head fully loaded
// - side output follows S flag at type II/III start; reset to 0
// - outer track flag for tracks 44-76, in every state
// - one write pulse per flux transition, one cycle wide at either density
// - read/write check ready first; not ready ends with interrupt
// - during write gate a low fault input ends writing
// - without write gate shared line is separator enable, low active
// - write command samples write protect; low ends and flags
// - density select low means double, high means single
// - track counts up inward, down outward; compared with seek target and with outer track range
// - command write-only, status read-only; host avoids writes while busy
// - crc-16 x16+x12+x5+1 preset ones over mark to crc
// - step pulse 2us double, 4us single; direction set first
// - rate codes give 3,6,10,15 ms step periods
`timescale 1ns/10ps
`include "fdc_map.svh"
module fdc_ctrl (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_drive_clk,
    input wire logic i_chip_sel_n,
    input wire logic i_bus_output_strobe_n,
    input wire logic i_bus_input_strobe_n,
    input wire logic i_reg_sel_lo,
    input wire logic i_reg_sel_hi,
    input wire logic [7:0] i_host_bus,
    output logic [7:0] o_host_bus,
    output logic o_host_bus_oe_n,
    output logic o_data_request,
    output logic o_command_done_irq,
    output logic o_step,
    output logic o_step_direction,
    output logic o_write_early,
    output logic o_write_late,
    input wire logic i_head_engaged_in,
    output logic o_side_select_out,
    output logic o_head_load_out,
    output logic o_outer_track_flag,
    output logic o_write_gate_out,
    output logic o_write_pulse_out,
    input wire logic i_write_fault_n,
    output logic o_separator_enable_n,
    output logic o_separator_enable_oe_n,
    input wire logic i_drive_ready,
    input wire logic i_track_zero_n,
    input wire logic i_index_pulse_in,
    input wire logic i_write_protect_in,
    input wire logic i_double_density_sel_n,
    input wire logic i_raw_read_n
);
    // host side state on i_mclk
    typedef struct packed {
        logic [1:0] we_s;
        logic [1:0] re_s;
        logic we_d;
        logic re_d;
        logic [7:0] cmd;
        logic [7:0] track;
        logic [7:0] sector;
        logic [7:0] data;
        logic data_req;
        logic irq;
        logic [7:0] bus_out;
        logic bus_oe_n;
        logic cmd_tog;
        logic [2:0] done_s;
        logic [2:0] ev_s;
        logic [7:0] ist_s0;
        logic [7:0] ist_s1;
    } fdc_host_t;
    // drive side state on i_drive_clk
    typedef struct packed {
        fdc_pkg::fdc_state_t st;
        logic [2:0] cmd_s;
        logic [7:0] cmd;
        logic [7:0] track;
        logic [7:0] target;
        logic [7:0] status;
        logic [15:0] cnt;
        logic [15:0] step_cyc;
        logic [7:0] shreg;
        logic [3:0] bits;
        logic dir;
        logic step;
        logic side;
        logic head_load_out;
        logic wg;
        logic wd;
        logic early;
        logic late;
        logic separator_enable_n_n;
        logic outer;
        logic done_tog;
        logic ev_tog;
        logic crc_pre;
        logic crc_sh;
        logic [1:0] rdy_s;
        logic [1:0] wf_s;
        logic [1:0] wp_s;
        logic [1:0] hlt_s;
        logic [1:0] t0_s;
        logic [1:0] dd_s;
        logic [1:0] rd_s;
        logic prev_bit;
    } fdc_drive_t;

    fdc_host_t h;
    fdc_host_t next_h;
    fdc_drive_t d;
    fdc_drive_t next_d;
    logic [15:0] crc;
    logic [1:0] sel;
    logic wr_edge;
    logic rd_edge;
    logic dbl;
    logic [15:0] rate_cyc;

    assign sel = {i_reg_sel_hi, i_reg_sel_lo};

    fdc_crc16 u_crc (
        .i_clk(i_drive_clk),
        .i_reset_n(i_reset_n),
        .i_preset(d.crc_pre),
        .i_shift(d.crc_sh),
        .i_bit(d.shreg[7]),
        .o_crc(crc)
    );

    // host register file
    always_comb begin
        next_h = h;
        next_h.we_s = {h.we_s[0], ~(i_bus_input_strobe_n | i_chip_sel_n)};
        next_h.re_s = {h.re_s[0], ~(i_bus_output_strobe_n | i_chip_sel_n)};
        next_h.we_d = h.we_s[1];
        next_h.re_d = h.re_s[1];
        next_h.done_s = {h.done_s[1:0], d.done_tog};
        next_h.ev_s = {h.ev_s[1:0], d.ev_tog};
        next_h.ist_s0 = d.status;
        next_h.ist_s1 = h.ist_s0;
        wr_edge = h.we_s[1] & ~h.we_d;
        rd_edge = h.re_s[1] & ~h.re_d;
        if (h.ev_s[2] != h.ev_s[1]) begin
            next_h.data_req = 1'b1;
        end
        if (h.done_s[2] != h.done_s[1]) begin
            next_h.irq = 1'b1;
            next_h.track = d.track;
        end
        if (wr_edge) begin
            case (sel)
                `FDC_SEL_STATUS: begin
                    next_h.cmd = ~i_host_bus;
                    next_h.cmd_tog = ~h.cmd_tog;
                    next_h.irq = 1'b0;
                end
                `FDC_SEL_TRACK: next_h.track = ~i_host_bus;
                `FDC_SEL_SECTOR: next_h.sector = ~i_host_bus;
                default: begin
                    next_h.data = ~i_host_bus;
                    next_h.data_req = 1'b0;
                end
            endcase
        end
        if (rd_edge) begin
            case (sel)
                `FDC_SEL_STATUS: begin
                    next_h.bus_out = ~{h.ist_s1[7:2], h.data_req, h.ist_s1[0]};
                    next_h.irq = 1'b0;
                end
                `FDC_SEL_TRACK: next_h.bus_out = ~h.track;
                `FDC_SEL_SECTOR: next_h.bus_out = ~h.sector;
                default: begin
                    next_h.bus_out = ~h.data;
                    next_h.data_req = 1'b0;
                end
            endcase
        end
        next_h.bus_oe_n = ~h.re_s[1];
    end

    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            h <= '0;
            h.cmd <= `FDC_CMD_RESET;
            h.sector <= `FDC_SECTOR_RESET;
            h.bus_out <= 8'hff;
            h.bus_oe_n <= 1'b1;
        end else begin
            h <= next_h;
        end
    end

    // drive sequencer
    assign dbl = ~d.dd_s[1];
    always_comb begin
        case (d.cmd[1:0])
            2'h0: rate_cyc = 16'(`FDC_RATE0_MS * `FDC_MS_CYC);
            2'h1: rate_cyc = 16'(`FDC_RATE1_MS * `FDC_MS_CYC);
            2'h2: rate_cyc = 16'(`FDC_RATE2_MS * `FDC_MS_CYC);
            default: rate_cyc = 16'(`FDC_RATE3_MS * `FDC_MS_CYC);
        endcase
    end

    always_comb begin
        next_d = d;
        next_d.cmd_s = {d.cmd_s[1:0], h.cmd_tog};
        next_d.rdy_s = {d.rdy_s[0], i_drive_ready};
        next_d.wf_s = {d.wf_s[0], i_write_fault_n};
        next_d.wp_s = {d.wp_s[0], i_write_protect_in};
        next_d.hlt_s = {d.hlt_s[0], i_head_engaged_in};
        next_d.t0_s = {d.t0_s[0], i_track_zero_n};
        next_d.dd_s = {d.dd_s[0], i_double_density_sel_n};
        next_d.rd_s = {d.rd_s[0], i_raw_read_n};
        next_d.crc_pre = 1'b0;
        next_d.crc_sh = 1'b0;
        next_d.wd = 1'b0;
        next_d.status[`FDC_ST_NOTREADY] = ~d.rdy_s[1];
        next_d.status[`FDC_ST_TRK0] = ~d.t0_s[1];
        next_d.outer = (d.track >= `FDC_OUTER_LO) && (d.track <= `FDC_OUTER_HI);
        next_d.separator_enable_n_n = d.wg ? 1'b1 : ~(d.st == fdc_pkg::ST_XFER && d.hlt_s[1]);
        case (d.st)
            fdc_pkg::ST_IDLE: begin
                if (d.cmd_s[2] != d.cmd_s[1]) begin
                    next_d.cmd = h.cmd;
                    next_d.target = h.data;
                    next_d.track = h.track;
                    next_d.status = '0;
                    next_d.status[`FDC_ST_BUSY] = 1'b1;
                    if (h.cmd[7:4] == 4'hd) begin
                        next_d.st = fdc_pkg::ST_DONE;
                    end else if (!h.cmd[7]) begin
                        next_d.head_load_out = h.cmd[`FDC_BIT_HLOAD];
                        next_d.st = fdc_pkg::ST_CHECK;
                    end else if (!d.rdy_s[1]) begin
                        next_d.st = fdc_pkg::ST_DONE;
                    end else begin
                        next_d.side = h.cmd[`FDC_BIT_SIDE];
                        next_d.head_load_out = 1'b1;
                        next_d.crc_pre = 1'b1;
                        if (h.cmd[5] && !d.wp_s[1]) begin
                            next_d.status[`FDC_ST_WPROT] = 1'b1;
                            next_d.st = fdc_pkg::ST_DONE;
                        end else begin
                            next_d.wg = h.cmd[5];
                            next_d.shreg = h.data;
                            next_d.bits = `FDC_BYTE_BITS;
                            next_d.st = fdc_pkg::ST_XFER;
                        end
                    end
                end
            end
            fdc_pkg::ST_CHECK: begin
                if (d.cmd[7:4] == 4'h0 && !d.t0_s[1]) begin
                    next_d.track = 8'h00;
                    next_d.st = fdc_pkg::ST_DONE;
                end else if (d.cmd[7:4] == 4'h1 && d.track == d.target) begin
                    next_d.st = fdc_pkg::ST_DONE;
                end else begin
                    if (d.cmd[7:5] == 3'h2) begin
                        next_d.dir = 1'b1;
                    end else if (d.cmd[7:5] == 3'h3) begin
                        next_d.dir = 1'b0;
                    end else if (d.cmd[7:5] == 3'h0) begin
                        next_d.dir = (d.cmd[4] && d.target > d.track);
                    end
                    next_d.cnt = 16'h0000;
                    next_d.step_cyc = dbl ? 16'(`FDC_STEP_PULSE_DD_CYC)
                                          : 16'(`FDC_STEP_PULSE_SD_CYC);
                    next_d.st = fdc_pkg::ST_STEP_HI;
                end
            end
            fdc_pkg::ST_STEP_HI: begin
                next_d.step = 1'b1;
                next_d.cnt = d.cnt + 16'h0001;
                if (d.cnt >= d.step_cyc) begin
                    next_d.step = 1'b0;
                    if (d.dir) begin
                        next_d.track = d.track + 8'h01;
                    end else begin
                        next_d.track = d.track - 8'h01;
                    end
                    next_d.cnt = 16'h0000;
                    next_d.st = fdc_pkg::ST_STEP_WAIT;
                end
            end
            fdc_pkg::ST_STEP_WAIT: begin
                next_d.cnt = d.cnt + 16'h0001;
                if (d.cnt + 16'h0001 >= rate_cyc) begin
                    next_d.st = (d.cmd[7:5] == 3'h0) ? fdc_pkg::ST_CHECK
                                                     : fdc_pkg::ST_DONE;
                end
            end
            fdc_pkg::ST_XFER: begin
                if (d.wg && !d.wf_s[1]) begin
                    next_d.status[`FDC_ST_FAULT] = 1'b1;
                    next_d.wg = 1'b0;
                    next_d.st = fdc_pkg::ST_DONE;
                end else if (d.hlt_s[1]) begin
                    if (d.bits == 4'h0) begin
                        next_d.status[`FDC_ST_CRC] = !d.wg && (crc != 16'h0000);
                        next_d.ev_tog = ~d.ev_tog;
                        next_d.wg = 1'b0;
                        next_d.st = fdc_pkg::ST_DONE;
                    end else if (d.wg) begin
                        next_d.wd = d.shreg[7];
                        next_d.early = d.shreg[7] & ~d.prev_bit;
                        next_d.late = d.shreg[7] & d.prev_bit;
                        next_d.prev_bit = d.shreg[7];
                        next_d.crc_sh = 1'b1;
                        next_d.shreg = {d.shreg[6:0], 1'b0};
                        next_d.bits = d.bits - 4'h1;
                        next_d.st = fdc_pkg::ST_WBIT;
                    end else if (d.rd_s[1] != d.prev_bit) begin
                        next_d.prev_bit = d.rd_s[1];
                        next_d.shreg = {d.shreg[6:0], ~d.rd_s[1]};
                        next_d.crc_sh = 1'b1;
                        next_d.bits = d.bits - 4'h1;
                    end
                end
            end
            fdc_pkg::ST_WBIT: begin
                next_d.early = 1'b0;
                next_d.late = 1'b0;
                next_d.st = fdc_pkg::ST_XFER;
            end
            fdc_pkg::ST_DONE: begin
                next_d.status[`FDC_ST_BUSY] = 1'b0;
                next_d.done_tog = ~d.done_tog;
                next_d.st = fdc_pkg::ST_IDLE;
            end
            default: next_d.st = fdc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_drive_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            d <= '0;
            d.st <= fdc_pkg::ST_IDLE;
            d.cmd_s <= 3'h1;
            d.cmd <= `FDC_CMD_RESET;
            d.separator_enable_n_n <= 1'b1;
            d.rdy_s <= 2'h3;
            d.wf_s <= 2'h3;
            d.wp_s <= 2'h3;
            d.t0_s <= 2'h3;
            d.rd_s <= 2'h3;
            d.prev_bit <= 1'b1;
        end else begin
            d <= next_d;
        end
    end

    assign o_host_bus = h.bus_out;
    assign o_host_bus_oe_n = h.bus_oe_n;
    assign o_data_request = h.data_req;
    assign o_command_done_irq = h.irq;
    assign o_step = d.step;
    assign o_step_direction = d.dir;
    assign o_write_early = d.early;
    assign o_write_late = d.late;
    assign o_side_select_out = d.side;
    assign o_head_load_out = d.head_load_out;
    assign o_outer_track_flag = d.outer;
    assign o_write_gate_out = d.wg;
    assign o_write_pulse_out = d.wd;
    assign o_separator_enable_n = d.separator_enable_n_n;
    assign o_separator_enable_oe_n = d.wg;
endmodule // fdc_ctrl

/* core/fdc_map.svh */
// register offsets, reset values, timing counts for the disk controller
`ifndef FDC_MAP_SVH
`define FDC_MAP_SVH
`define FDC_SEL_STATUS 2'h0
`define FDC_SEL_TRACK 2'h1
`define FDC_SEL_SECTOR 2'h2
`define FDC_SEL_DATA 2'h3
`define FDC_CMD_RESET 8'h03
`define FDC_SECTOR_RESET 8'h01
`define FDC_CLK_MHZ 100
`define FDC_LINK_MHZ 2
`define FDC_STEP_PULSE_DD_US 2
`define FDC_STEP_PULSE_SD_US 4
`define FDC_STEP_PULSE_DD_CYC (`FDC_STEP_PULSE_DD_US * `FDC_LINK_MHZ)
`define FDC_STEP_PULSE_SD_CYC (`FDC_STEP_PULSE_SD_US * `FDC_LINK_MHZ)
`define FDC_RATE0_MS 3
`define FDC_RATE1_MS 6
`define FDC_RATE2_MS 10
`define FDC_RATE3_MS 15
`define FDC_MS_CYC (1000 * `FDC_LINK_MHZ)
`define FDC_WPULSE_DD_NS 250
`define FDC_WPULSE_SD_NS 500
`define FDC_WPULSE_DD_CYC 1
`define FDC_WPULSE_SD_CYC 1
`define FDC_OUTER_LO 8'h2c
`define FDC_OUTER_HI 8'h4c
`define FDC_TRACK_MAX 8'h4c
`define FDC_CRC_PRESET 16'hffff
`define FDC_CRC_POLY 16'h1021
`define FDC_ST_NOTREADY 7
`define FDC_ST_WPROT 6
`define FDC_ST_HEAD 5
`define FDC_ST_FAULT 5
`define FDC_ST_RNF 4
`define FDC_ST_CRC 3
`define FDC_ST_TRK0 2
`define FDC_ST_DRQ 1
`define FDC_ST_BUSY 0
`define FDC_BIT_SIDE 3
`define FDC_BIT_HLOAD 3
`define FDC_BIT_VERIFY 2
`define FDC_BIT_UPDATE 4
`define FDC_BYTE_BITS 4'h8
`define FDC_STEP_CNT_W 16
`endif

/* core/fdc_pkg.sv */
// types for the disk controller
package fdc_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_STEP_HI, ST_STEP_WAIT, ST_CHECK, ST_XFER, ST_WBIT, ST_DONE
    } fdc_state_t;
    typedef enum logic [2:0] {
        CMD_RESTORE, CMD_SEEK, CMD_STEP, CMD_STEP_IN, CMD_STEP_OUT,
        CMD_READ, CMD_WRITE, CMD_FORCE
    } fdc_cmd_t;
endpackage

/* core/fdc_crc16.sv */
// serial crc-16 generator and checker
`timescale 1ns/10ps
`include "fdc_map.svh"
module fdc_crc16 (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_preset,
    input wire logic i_shift,
    input wire logic i_bit,
    output logic [15:0] o_crc
);
    typedef struct packed {
        logic [15:0] crc;
    } fdc_crc_state_t;
    fdc_crc_state_t r;
    fdc_crc_state_t next_r;
    always_comb begin
        next_r = r;
        if (i_preset) begin
            next_r.crc = `FDC_CRC_PRESET;
        end else if (i_shift) begin
            next_r.crc = {r.crc[14:0], 1'b0} ^
                ((r.crc[15] ^ i_bit) ? `FDC_CRC_POLY : 16'h0000);
        end
    end
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            r <= '{crc: `FDC_CRC_PRESET};
        end else begin
            r <= next_r;
        end
    end
    assign o_crc = r.crc;
endmodule // fdc_crc16

/* testbench/fdc_ctrl_checker.sv */
// concurrent checks on the disk controller ports
`timescale 1ns/10ps
module fdc_ctrl_checker (
    input wire logic i_mclk,
    input wire logic i_reset_n,
    input wire logic i_drive_clk,
    input wire logic i_chip_sel_n,
    input wire logic i_bus_output_strobe_n,
    input wire logic i_bus_input_strobe_n,
    input wire logic i_reg_sel_lo,
    input wire logic i_reg_sel_hi,
    input wire logic i_drive_ready,
    input wire logic i_write_protect_in,
    input wire logic i_double_density_sel_n,
    input wire logic o_host_bus_oe_n,
    input wire logic o_data_request,
    input wire logic o_command_done_irq,
    input wire logic o_step,
    input wire logic o_step_direction,
    input wire logic o_side_select_out,
    input wire logic o_write_gate_out
);
    logic rd_st;
    logic rd_dat;
    logic cmd_wr;
    logic [7:0] since_cmd;
    logic [3:0] step_len;
    assign rd_st = !i_chip_sel_n && !i_bus_output_strobe_n && !i_reg_sel_hi && !i_reg_sel_lo;
    assign rd_dat = !i_chip_sel_n && !i_bus_output_strobe_n && i_reg_sel_hi && i_reg_sel_lo;
    assign cmd_wr = !i_chip_sel_n && !i_bus_input_strobe_n && !i_reg_sel_hi && !i_reg_sel_lo;
    // cycles since the last command write
    always_ff @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) since_cmd <= 8'hff;
        else if (cmd_wr) since_cmd <= 8'h00;
        else if (since_cmd != 8'hff) since_cmd <= since_cmd + 8'h01;
    end
    // length of the current step pulse in link cycles
    always_ff @(posedge i_drive_clk or negedge i_reset_n) begin
        if (!i_reset_n) step_len <= 4'h0;
        else step_len <= o_step ? step_len + 4'h1 : 4'h0;
    end
    a_reset_quiet: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $rose(i_reset_n) |-> o_host_bus_oe_n && !o_side_select_out && !o_write_gate_out)
        else $error("outputs not quiet after reset");
    a_oe_on_read: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $fell(o_host_bus_oe_n) |-> $past(!i_chip_sel_n && !i_bus_output_strobe_n, 2))
        else $error("bus driven without read strobe");
    a_oe_release: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        i_bus_output_strobe_n [*5] |-> o_host_bus_oe_n)
        else $error("bus still driven after read");
    a_irq_status_clr: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $rose(rd_st) |-> ##[1:6] !o_command_done_irq)
        else $error("status read left interrupt set");
    a_drq_data_clr: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $rose(rd_dat) && o_data_request |-> ##[1:6] !o_data_request)
        else $error("data read left request set");
    a_side_at_cmd: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $changed(o_side_select_out) |-> since_cmd < 8'd200)
        else $error("side changed outside command start");
    a_wgate_protect: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        $rose(o_write_gate_out) |-> i_write_protect_in && i_drive_ready)
        else $error("write gate on protected or not ready drive");
    a_step_width: assert property (@(posedge i_drive_clk) disable iff (!i_reset_n)
        $fell(o_step) |-> step_len == (i_double_density_sel_n ? 4'h8 : 4'h4))
        else $error("step pulse width wrong");
    a_dir_settled: assert property (@(posedge i_drive_clk) disable iff (!i_reset_n)
        o_step |-> $stable(o_step_direction))
        else $error("direction moved during step");
    c_step: cover property (@(posedge i_drive_clk) disable iff (!i_reset_n) $rose(o_step));
    c_drq: cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(o_data_request));
    c_wgate: cover property (@(posedge i_mclk) disable iff (!i_reset_n) $rose(o_write_gate_out));
endmodule // fdc_ctrl_checker
bind fdc_ctrl fdc_ctrl_checker chk_i (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
    .i_drive_clk(i_drive_clk), .i_chip_sel_n(i_chip_sel_n),
    .i_bus_output_strobe_n(i_bus_output_strobe_n), .i_bus_input_strobe_n(i_bus_input_strobe_n),
    .i_reg_sel_lo(i_reg_sel_lo), .i_reg_sel_hi(i_reg_sel_hi), .i_drive_ready(i_drive_ready),
    .i_write_protect_in(i_write_protect_in), .i_double_density_sel_n(i_double_density_sel_n),
    .o_host_bus_oe_n(o_host_bus_oe_n), .o_data_request(o_data_request),
    .o_command_done_irq(o_command_done_irq), .o_step(o_step),
    .o_step_direction(o_step_direction), .o_side_select_out(o_side_select_out),
    .o_write_gate_out(o_write_gate_out));

/* testbench/fdc_drive_model.sv */
// drive model: head position, index, head engage, read pulses
`timescale 1ns/10ps
module fdc_drive_model (
    input wire logic i_drive_clk,
    input wire logic i_step,
    input wire logic i_step_direction,
    input wire logic i_head_load_out,
    input wire logic i_write_pulse_out,
    output logic o_track_zero_n,
    output logic o_index_pulse_in,
    output logic o_head_engaged_in,
    output logic o_raw_read_n,
    output logic o_last_dir,
    output int o_steps,
    output int o_wpulses
);
    logic [7:0] track = 8'h00;
    logic [11:0] tick = 12'h000;
    logic [4:0] hl_cnt = 5'h00;
    logic step_d = 1'b0;
    logic wp_d = 1'b0;
    initial begin
        o_last_dir = 1'b0;
        o_steps = 0;
        o_wpulses = 0;
    end
    always @(posedge i_drive_clk) begin
        tick <= tick + 12'h001;
        step_d <= i_step;
        wp_d <= i_write_pulse_out;
        hl_cnt <= !i_head_load_out ? 5'h00 : (hl_cnt == 5'h1f ? hl_cnt : hl_cnt + 5'h01);
        if (i_step && !step_d) begin
            o_steps <= o_steps + 1;
            o_last_dir <= i_step_direction;
            if (i_step_direction) track <= track + 8'h01;
            else if (track != 8'h00) track <= track - 8'h01;
        end
        if (i_write_pulse_out && !wp_d) o_wpulses <= o_wpulses + 1;
    end
    assign o_track_zero_n = (track != 8'h00);
    assign o_index_pulse_in = (tick[11:4] == 8'h00);
    assign o_head_engaged_in = (hl_cnt == 5'h1f);
    assign o_raw_read_n = (tick[2:0] != {tick[3], 2'b01});
endmodule // fdc_drive_model

/* testbench/fdc_ctrl_test.sv */
// self-checking bench for the disk controller
`timescale 1ns/10ps
module fdc_ctrl_test;
    logic i_mclk = 1'b0;
    logic i_drive_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1, sel_lo = 1'b0, sel_hi = 1'b0;
    logic ready = 1'b1, wprot_n = 1'b1, double_density_sel_n_n = 1'b0, fault_n = 1'b1;
    logic [7:0] bus_in = 8'hff, hbus, rv, tv;
    logic oe_n, data_request, irq, step, dir, side, head_load_out, wg, wpulse, sep_n, sep_oe_n, outer;
    logic trk0_n, index_p, engaged, raw_n, last_dir, wf_line;
    logic [1:0] s;
    int steps, wpulses;
    int err_count = 0, checks_done = 0;
    logic [31:0] seed = 32'h642c921b;
    realtime t0;
    always #5 i_mclk = ~i_mclk;
    initial begin
        #3.3;
        forever #40 i_drive_clk = ~i_drive_clk;
    end
    assign wf_line = sep_oe_n ? fault_n : sep_n;
    fdc_ctrl dut (.i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_drive_clk(i_drive_clk),
        .i_chip_sel_n(cs_n), .i_bus_output_strobe_n(rd_n), .i_bus_input_strobe_n(wr_n),
        .i_reg_sel_lo(sel_lo), .i_reg_sel_hi(sel_hi), .i_host_bus(bus_in), .o_host_bus(hbus),
        .o_host_bus_oe_n(oe_n), .o_data_request(data_request), .o_command_done_irq(irq), .o_step(step),
        .o_step_direction(dir), .o_write_early(), .o_write_late(), .i_head_engaged_in(engaged),
        .o_side_select_out(side), .o_head_load_out(head_load_out), .o_outer_track_flag(outer),
        .o_write_gate_out(wg), .o_write_pulse_out(wpulse), .i_write_fault_n(wf_line),
        .o_separator_enable_n(sep_n), .o_separator_enable_oe_n(sep_oe_n), .i_drive_ready(ready),
        .i_track_zero_n(trk0_n), .i_index_pulse_in(index_p), .i_write_protect_in(wprot_n),
        .i_double_density_sel_n(double_density_sel_n_n), .i_raw_read_n(raw_n));
    fdc_drive_model drive (.i_drive_clk(i_drive_clk), .i_step(step), .i_step_direction(dir),
        .i_head_load_out(head_load_out), .i_write_pulse_out(wpulse), .o_track_zero_n(trk0_n),
        .o_index_pulse_in(index_p), .o_head_engaged_in(engaged), .o_raw_read_n(raw_n),
        .o_last_dir(last_dir), .o_steps(steps), .o_wpulses(wpulses));
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [1:0] sel, input logic [7:0] wv);
        @(posedge i_mclk);
        cs_n <= 1'b0;
        sel_hi <= sel[1];
        sel_lo <= sel[0];
        bus_in <= ~wv;
        if (wr) wr_n <= 1'b0;
        else rd_n <= 1'b0;
        repeat (6) @(posedge i_mclk);
        rv = ~hbus;
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        bus_in <= wv;
        repeat (5) @(posedge i_mclk);
    endtask
    task automatic wait_for(input logic any, input int lim);
        int n;
        n = 0;
        while (n < lim && (irq | (any & data_request)) !== 1'b1) begin
            @(posedge i_mclk);
            n++;
        end
        chk({7'h0, irq | (any & data_request)}, 8'h01);
    endtask
    task automatic give_verdict();
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        #1000000;
        err_count++;
        give_verdict();
    end
    initial begin
        repeat (16) @(posedge i_mclk);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        wait_for(1'b0, 3000);
        xfer(1'b0, 2'h2, 8'h00);
        chk(rv, 8'h01);
        xfer(1'b0, 2'h0, 8'h00);
        chk(rv & 8'h80, 8'h00);
        chk({7'h0, irq}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            seed = xs(seed);
            s = 2'(i % 3) + 2'h1;
            xfer(1'b1, s, seed[7:0]);
            xfer(1'b0, s, 8'h00);
            chk(rv, seed[7:0]);
        end
        ready <= 1'b0;
        xfer(1'b1, 2'h0, 8'h80);
        wait_for(1'b0, 3000);
        xfer(1'b0, 2'h0, 8'h00);
        chk(rv & 8'h81, 8'h80);
        ready <= 1'b1;
        wprot_n <= 1'b0;
        xfer(1'b1, 2'h0, 8'ha0);
        wait_for(1'b0, 3000);
        xfer(1'b0, 2'h0, 8'h00);
        chk(rv & 8'h40, 8'h40);
        chk(8'(wpulses), 8'h00);
        wprot_n <= 1'b1;
        xfer(1'b1, 2'h0, 8'ha0);
        wait_for(1'b1, 5000);
        seed = xs(seed);
        xfer(1'b1, 2'h3, seed[7:0]);
        chk({7'h0, data_request}, 8'h00);
        wait_for(1'b0, 20000);
        chk({7'h0, wpulses != 0}, 8'h01);
        xfer(1'b0, 2'h0, 8'h00);
        xfer(1'b1, 2'h0, 8'h88);
        wait_for(1'b1, 20000);
        chk({7'h0, side}, 8'h01);
        if (data_request === 1'b1) begin
            xfer(1'b0, 2'h3, 8'h00);
            chk({7'h0, data_request}, 8'h00);
        end
        xfer(1'b1, 2'h0, 8'hd8);
        wait_for(1'b0, 3000);
        xfer(1'b0, 2'h0, 8'h00);
        seed = xs(seed);
        tv = {2'b00, seed[5:0]};
        xfer(1'b1, 2'h1, tv);
        t0 = $realtime;
        xfer(1'b1, 2'h0, 8'h50);
        wait_for(1'b0, 70000);
        chk({7'h0, ($realtime - t0) > 470000.0}, 8'h01);
        xfer(1'b0, 2'h1, 8'h00);
        chk(rv, tv + 8'h01);
        chk({7'h0, outer}, {7'h0, tv + 8'h01 >= 8'h2c});
        chk({7'h0, last_dir}, 8'h01);
        chk(8'(steps), 8'h01);
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        chk({6'h0, side, oe_n}, 8'h01);
        i_reset_n <= 1'b1;
        repeat (3) @(posedge i_mclk);
        xfer(1'b0, 2'h2, 8'h00);
        chk(rv, 8'h01);
        give_verdict();
    end
endmodule // fdc_ctrl_test
